// >>> logic/status_word_flags.sv
// status word, operand register and flag-producing ALU behind an APB slave
// How it works
// - an add or subtract that carries (borrows) out of bit seven sets the carry bit.
// - bit operations read and write the carry bit as their single-bit operand.
// - a carry across the nibble boundary sets the half-carry bit.
// - the two user flags change only by software writes.
// - bits four and three form the working register bank selector.
// - the signed wrap bit is the exclusive-or of the carries out of bits six and seven.
// - bit zero always follows the parity of the operand register.
// - the status word sits at address d0h, carry in bit seven, parity in bit zero.
// - the operand register is readable and writable at address ech.
//
// Added by the designer: register access over APB.
module status_word_flags
    import status_flags_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // core alu request
    input  wire alu_req_s    alu_req,
    // results
    output alu_res_s         alu_res,
    output logic [7:0]       status_word,
    output logic [7:0]       main_operand_register,
    output logic [7:0]       bank_base
);

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    state_s     cur_q;
    state_s     nxt_d;
    logic       opnd_wr;
    logic       stat_wr;
    logic       mapped;
    logic [7:0] opnd;
    logic [7:0] sum8;
    logic       cin;
    logic       sub;
    logic       half_c;
    logic       c6;
    logic       c7;
    logic       bit_res;
    logic       do_arith;

    assign opnd_wr = psel && penable && pwrite && (paddr == OPERAND_REG_ADDR);
    assign stat_wr = psel && penable && pwrite && (paddr == STATUS_WORD_ADDR);
    // reserved control word decodes as mapped so writes to it complete without error
    assign mapped = (paddr == OPERAND_REG_ADDR) || (paddr == STATUS_WORD_ADDR)
                 || (paddr == ALU_CTRL_ADDR) || (paddr == BANK_BASE_ADDR);

    // ------------------------------------------------------------
    // adder taps
    // ------------------------------------------------------------
    // subtract is an add of the inverted operand with inverted carry in
    assign sub      = (alu_req.op == OP_SUBB);
    assign cin      = (alu_req.op == OP_ADD) ? 1'b0 : (cur_q.status_q[CARRY_BIT] ^ sub);
    assign opnd     = sub ? ~alu_req.operand : alu_req.operand;
    assign do_arith = alu_req.valid && (alu_req.op inside {OP_ADD, OP_ADDC, OP_SUBB});

    // three widths give the nibble, bit six and bit seven carries apart
    carry_slice #(.WIDTH(4)) nibble_add
    (
        .a    (cur_q.operand_q[3:0]),
        .b    (opnd[3:0]),
        .cin  (cin),
        .sum  (),
        .cout (half_c)
    );
    carry_slice #(.WIDTH(7)) seven_add
    (
        .a    (cur_q.operand_q[6:0]),
        .b    (opnd[6:0]),
        .cin  (cin),
        .sum  (),
        .cout (c6)
    );
    carry_slice #(.WIDTH(8)) byte_add
    (
        .a    (cur_q.operand_q),
        .b    (opnd),
        .cin  (cin),
        .sum  (sum8),
        .cout (c7)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    always_comb
    begin
        nxt_d    = cur_q;
        bit_res  = cur_q.status_q[CARRY_BIT];
        unique case (alu_req.op)
            OP_SETC: bit_res = 1'b1;
            OP_CLRC: bit_res = 1'b0;
            OP_CPLC: bit_res = ~cur_q.status_q[CARRY_BIT];
            OP_ANLC: bit_res = cur_q.status_q[CARRY_BIT] & alu_req.bit_in;
            OP_ORLC: bit_res = cur_q.status_q[CARRY_BIT] | alu_req.bit_in;
            OP_ADD, OP_ADDC, OP_SUBB: bit_res = cur_q.status_q[CARRY_BIT];
        endcase
        // software writes first; alu updates take priority in the same cycle
        if (stat_wr)
        begin
            nxt_d.status_q = pwdata[7:0];
        end
        if (opnd_wr)
        begin
            nxt_d.operand_q = pwdata[7:0];
        end
        if (do_arith)
        begin
            // borrow is the inverted carry on subtract
            nxt_d.status_q[CARRY_BIT] = sub ? ~c7 : c7;
            nxt_d.status_q[HALF_BIT]  = sub ? ~half_c : half_c;
            nxt_d.status_q[WRAP_BIT]  = c6 ^ c7;
            nxt_d.operand_q           = sum8;
            nxt_d.res_q.result        = sum8;
            nxt_d.res_q.carry         = sub ? ~c7 : c7;
            nxt_d.res_q.half          = sub ? ~half_c : half_c;
            nxt_d.res_q.wrap          = c6 ^ c7;
        end
        else if (alu_req.valid)
        begin
            nxt_d.status_q[CARRY_BIT] = bit_res;
            nxt_d.res_q.carry         = bit_res;
        end
        // user flags and bank bits only move on a software write
        // parity tracks the next operand value, writes to it are dropped
        nxt_d.status_q[PARITY_BIT] = ^nxt_d.operand_q;
        nxt_d.prdata_q = 32'h0000_0000;
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                STATUS_WORD_ADDR: nxt_d.prdata_q = {24'h00_0000, cur_q.status_q};
                OPERAND_REG_ADDR: nxt_d.prdata_q = {24'h00_0000, cur_q.operand_q};
                BANK_BASE_ADDR:   nxt_d.prdata_q = {24'h00_0000, bank_base};
                default:          nxt_d.prdata_q = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_q <= '{status_q: STATUS_RESET, operand_q: OPERAND_RESET,
                       res_q: '0, prdata_q: 32'h0000_0000};
        end
        else
        begin
            cur_q <= nxt_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // ready on the first access cycle keeps every transfer two cycles long
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = cur_q.prdata_q;
    assign alu_res = cur_q.res_q;
    assign status_word           = cur_q.status_q;
    assign main_operand_register = cur_q.operand_q;
    // selector times eight is the bank start
    assign bank_base = {3'h0, cur_q.status_q[BANK_HI_BIT:BANK_LO_BIT], 3'h0};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    parity_track_a: assert property (
        status_word[PARITY_BIT] == ^main_operand_register)
        else $error("parity bit not matching operand");
    parity_nowrite_a: assert property (
        stat_wr && !opnd_wr && !alu_req.valid
        |=> status_word[PARITY_BIT] == $past(^main_operand_register))
        else $error("parity bit took a software write");
    carry_add_a: assert property (
        do_arith && alu_req.op == OP_ADD
        |=> status_word[CARRY_BIT] == $past(c7))
        else $error("carry wrong after add");
    half_add_a: assert property (
        do_arith && alu_req.op == OP_ADD
        |=> status_word[HALF_BIT] == $past(half_c))
        else $error("half carry wrong after add");
    wrap_flag_a: assert property (
        do_arith
        |=> status_word[WRAP_BIT] == $past(c6 ^ c7))
        else $error("signed wrap flag wrong");
    user_flags_a: assert property (
        !stat_wr
        |=> {status_word[UF0_BIT], status_word[UF1_BIT]}
            == $past({status_word[UF0_BIT], status_word[UF1_BIT]}))
        else $error("user flag changed without write");
    bank_map_a: assert property (
        bank_base
        == ({6'h00, status_word[BANK_HI_BIT:BANK_LO_BIT]} << BANK_SHIFT))
        else $error("bank base mismatch");
    bit_and_a: assert property (
        alu_req.valid && alu_req.op == OP_ANLC
        |=> status_word[CARRY_BIT] == $past(status_word[CARRY_BIT] & alu_req.bit_in))
        else $error("carry bit-and wrong");
    read_status_a: assert property (
        psel && !penable && !pwrite && paddr == STATUS_WORD_ADDR
        |=> prdata[7:0] == $past(status_word))
        else $error("status read data wrong");
    carry_sub_a: assert property (
        do_arith && alu_req.op == OP_SUBB
        |=> status_word[CARRY_BIT] == !$past(c7))
        else $error("borrow wrong after subtract");
    half_sub_a: assert property (
        do_arith && alu_req.op == OP_SUBB
        |=> status_word[HALF_BIT] == !$past(half_c))
        else $error("half borrow wrong after subtract");
    bit_or_a: assert property (
        alu_req.valid && alu_req.op == OP_ORLC
        |=> status_word[CARRY_BIT] == $past(status_word[CARRY_BIT] | alu_req.bit_in))
        else $error("carry bit-or wrong");
    bit_set_a: assert property (
        alu_req.valid && alu_req.op == OP_SETC
        |=> status_word[CARRY_BIT])
        else $error("carry not set");
    bit_clear_a: assert property (
        alu_req.valid && alu_req.op == OP_CLRC
        |=> !status_word[CARRY_BIT])
        else $error("carry not cleared");
    bit_flip_a: assert property (
        alu_req.valid && alu_req.op == OP_CPLC
        |=> status_word[CARRY_BIT] == !$past(status_word[CARRY_BIT]))
        else $error("carry not complemented");
    bank_hold_a: assert property (
        !stat_wr
        |=> $stable(status_word[BANK_HI_BIT:BANK_LO_BIT]))
        else $error("bank selector changed without write");
    status_write_a: assert property (
        stat_wr && !alu_req.valid
        |=> status_word[CARRY_BIT:UF1_BIT] == $past(pwdata[CARRY_BIT:UF1_BIT]))
        else $error("status write not taken");
    operand_write_a: assert property (
        opnd_wr && !do_arith
        |=> main_operand_register == $past(pwdata[7:0]))
        else $error("operand write not taken");
    read_operand_a: assert property (
        psel && !penable && !pwrite && paddr == OPERAND_REG_ADDR
        |=> prdata[7:0] == $past(main_operand_register))
        else $error("operand read data wrong");
    result_echo_a: assert property (
        do_arith
        |=> alu_res.result == main_operand_register)
        else $error("alu result not in operand register");
    carry_echo_a: assert property (
        alu_req.valid
        |=> alu_res.carry == status_word[CARRY_BIT])
        else $error("alu carry not matching status word");
    read_bank_a: assert property (
        psel && !penable && !pwrite && paddr == BANK_BASE_ADDR
        |=> prdata[7:0] == $past(bank_base))
        else $error("bank base read data wrong");
    wrap_keep_a: assert property (
        !do_arith && !stat_wr
        |=> $stable(status_word[WRAP_BIT]))
        else $error("wrap flag moved without an operation");
    half_keep_a: assert property (
        !do_arith && !stat_wr
        |=> $stable(status_word[HALF_BIT]))
        else $error("half carry moved without an operation");

    // ------------------------------------------------------------
    // scenario covers
    // ------------------------------------------------------------
    add_carry_c: cover property (do_arith && c7);
    sub_wrap_c:  cover property (do_arith && sub && (c6 ^ c7));
    sub_borrow_c: cover property (do_arith && sub && !c7);
    bank_three_c: cover property (status_word[BANK_HI_BIT:BANK_LO_BIT] == 2'b11);
    bit_or_c:    cover property (alu_req.valid && alu_req.op == OP_ORLC);
endmodule

// ------------------------------------------------------------
// carry adder slice
// ------------------------------------------------------------
// plain adder of the given width; the carry out feeds the flags, and the byte sum also sets the parity
module carry_slice
    import status_flags_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // addends
    input  wire logic [WIDTH-1:0] a,
    input  wire logic [WIDTH-1:0] b,
    input  wire logic             cin,
    // result
    output logic      [WIDTH-1:0] sum,
    output logic                  cout
);

    logic [WIDTH:0] total;

    assign total = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
    assign sum   = total[WIDTH-1:0];
    assign cout  = total[WIDTH];
endmodule

// >>> logic/psw_pkg.sv
// constants and carriers for the status word block
package status_flags_pkg;
    localparam logic [11:0] STATUS_WORD_ADDR  = 12'h0d0;
    localparam logic [11:0] OPERAND_REG_ADDR  = 12'h0ec;
    localparam logic [11:0] ALU_CTRL_ADDR     = 12'h100;
    localparam logic [11:0] BANK_BASE_ADDR    = 12'h104;
    localparam int          CARRY_BIT         = 7;
    localparam int          HALF_BIT          = 6;
    localparam int          UF0_BIT           = 5;
    localparam int          BANK_HI_BIT       = 4;
    localparam int          BANK_LO_BIT       = 3;
    localparam int          WRAP_BIT          = 2;
    localparam int          UF1_BIT           = 1;
    localparam int          PARITY_BIT        = 0;
    localparam logic [7:0]  STATUS_RESET      = 8'h00;
    localparam logic [7:0]  OPERAND_RESET     = 8'h00;
    localparam logic [2:0]  BANK_SHIFT        = 3'h3;

    typedef enum logic [2:0]
    {
        OP_ADD  = 3'b000,
        OP_ADDC = 3'b001,
        OP_SUBB = 3'b010,
        OP_SETC = 3'b011,
        OP_CLRC = 3'b100,
        OP_CPLC = 3'b101,
        OP_ANLC = 3'b110,
        OP_ORLC = 3'b111
    } alu_op_e;

    typedef struct packed
    {
        logic       valid;
        alu_op_e    op;
        logic [7:0] operand;
        logic       bit_in;
    } alu_req_s;

    typedef struct packed
    {
        logic [7:0] result;
        logic       carry;
        logic       half;
        logic       wrap;
    } alu_res_s;

    typedef struct packed
    {
        logic [7:0] status_q;
        logic [7:0] operand_q;
        alu_res_s   res_q;
        logic [31:0] prdata_q;
    } state_s;
endpackage

// >>> tb/tb_status_word_flags.sv
// self-checking bench for the status word block over apb
module tb_status_word_flags
    import status_flags_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    alu_req_s    alu_req = '0;
    alu_res_s    alu_res;
    logic [7:0]  status_word;
    logic [7:0]  main_operand_register;
    logic [7:0]  bank_base;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  es      = 8'h00;
    logic [7:0]  eo      = 8'h00;
    int          failures = 0;
    int          n_checks = 0;
    // op, operand, bit input; start value and carry differ per step on purpose
    logic [11:0] tbl [10] = '{{OP_ADD, 8'h08, 1'b0}, {OP_ADD, 8'hf1, 1'b0},
        {OP_ADDC, 8'h7f, 1'b0}, {OP_SUBB, 8'h01, 1'b0}, {OP_SUBB, 8'h80, 1'b0},
        {OP_CLRC, 8'h00, 1'b0}, {OP_SETC, 8'h00, 1'b0}, {OP_ANLC, 8'h00, 1'b0},
        {OP_ORLC, 8'h00, 1'b1}, {OP_CPLC, 8'h00, 1'b0}};

    always #4 pclk = ~pclk;

    status_word_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .alu_req(alu_req), .alu_res(alu_res), .status_word(status_word),
        .main_operand_register(main_operand_register), .bank_base(bank_base));

    task automatic conclude();
        if (failures == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    // one setup and access phase; the access phase waits for pready, for up to 20 cycles
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1)
        begin
            failures++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
        if (a == OPERAND_REG_ADDR)
            eo = d;
        if (a == STATUS_WORD_ADDR)
            es = d;
        es[0] = ^eo;
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(nm, {24'h00_0000, e}, rd);
    endtask

    task automatic alu(input logic [11:0] t);
        alu_op_e    o;
        logic [7:0] bb;
        logic [7:0] r;
        logic       sub;
        logic       ci;
        logic       c7;
        logic       h;
        logic       c6;
        o = alu_op_e'(t[11:9]);
        sub = (o == OP_SUBB);
        bb = sub ? ~t[8:1] : t[8:1];
        ci = (o == OP_ADD) ? 1'b0 : es[7] ^ sub;
        {c7, r} = {1'b0, eo} + {1'b0, bb} + {8'h00, ci};
        h = (int'(eo[3:0]) + int'(bb[3:0]) + int'(ci)) > 15;
        c6 = (int'(eo[6:0]) + int'(bb[6:0]) + int'(ci)) > 127;
        @(posedge pclk);
        alu_req <= '{1'b1, o, t[8:1], t[0]};
        @(posedge pclk);
        alu_req.valid <= 1'b0;
        // registered results move at that edge, so look once they settle
        @(negedge pclk);
        // subtract reports borrows, so the adder carries are inverted
        case (o)
            OP_SETC: es[7] = 1'b1;
            OP_CLRC: es[7] = 1'b0;
            OP_CPLC: es[7] = ~es[7];
            OP_ANLC: es[7] = es[7] & t[0];
            OP_ORLC: es[7] = es[7] | t[0];
            default:
            begin
                eo = r;
                es = {c7 ^ sub, h ^ sub, es[5:3], c6 ^ c7, es[1], ^r};
                chk("alu_res", {21'h0, r, c7 ^ sub, h ^ sub, c6 ^ c7}, {21'h0, alu_res});
            end
        endcase
        chk("alu_res carry", {31'h0, es[7]}, {31'h0, alu_res.carry});
        chk("status_word", {24'h0, es}, {24'h0, status_word});
        chk("operand", {24'h0, eo}, {24'h0, main_operand_register});
    endtask

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc("status reset", STATUS_WORD_ADDR, 8'h00);
        rdc("operand reset", OPERAND_REG_ADDR, 8'h00);
        for (int n = 0; n < 4; n++)
        begin
            wr(STATUS_WORD_ADDR, 8'h22 | 8'(n << 3));
            rdc("status bank", STATUS_WORD_ADDR, es);
            chk("bank_base", 32'(n * 8), {24'h00_0000, bank_base});
        end
        wr(STATUS_WORD_ADDR, 8'hff);
        rdc("parity ignores write", STATUS_WORD_ADDR, 8'hfe);
        wr(OPERAND_REG_ADDR, 8'h07);
        rdc("operand", OPERAND_REG_ADDR, 8'h07);
        rdc("parity odd", STATUS_WORD_ADDR, 8'hff);
        for (int k = 0; k < 10; k++)
            alu(tbl[k]);
        apb(1'b0, 12'h0f0, 8'h00);
        chk("unmapped read", 32'h0000_0000, rd);
        chk("unmapped error", 32'h0000_0001, {31'h0, err});
        apb(1'b1, 12'h0f0, 8'h00);
        chk("unmapped write error", 32'h0000_0001, {31'h0, err});
        rdc("bank read", BANK_BASE_ADDR, 8'h18);
        apb(1'b1, ALU_CTRL_ADDR, 8'hff);
        chk("reserved write error", 32'h0000_0000, {31'h0, err});
        rdc("status kept", STATUS_WORD_ADDR, es);
        conclude();
    end
endmodule
